/* File: rtl/dsd_consts.svh */
`ifndef DSD_CONSTS_SVH
`define DSD_CONSTS_SVH

// Register addresses
`define DSD_A_INT      5'h06
`define DSD_A_FRAC     5'h07
`define DSD_A_NDN_HI   5'h0C
`define DSD_A_NDN_LO   5'h0D
`define DSD_A_MOD      5'h0E
`define DSD_A_DIV      5'h0F
`define DSD_A_DWU_HI   5'h10
`define DSD_A_DWU_LO   5'h11
`define DSD_A_STU_HI   5'h12
`define DSD_A_STU_LO   5'h13
`define DSD_A_NU_HI    5'h14
`define DSD_A_NU_LO    5'h15
`define DSD_A_STD_HI   5'h19
`define DSD_A_STD_LO   5'h1A
`define DSD_A_DWD_HI   5'h1B
`define DSD_A_DWD_LO   5'h1C
`define DSD_A_STAT     5'h1D

// Storage index of each register
`define DSD_NREG       16
`define DSD_I_INT      0
`define DSD_I_FRAC     1
`define DSD_I_NDN_HI   2
`define DSD_I_NDN_LO   3
`define DSD_I_MOD      4
`define DSD_I_DIV      5
`define DSD_I_DWU_HI   6
`define DSD_I_DWU_LO   7
`define DSD_I_STU_HI   8
`define DSD_I_STU_LO   9
`define DSD_I_NU_HI    10
`define DSD_I_NU_LO    11
`define DSD_I_STD_HI   12
`define DSD_I_STD_LO   13
`define DSD_I_DWD_HI   14
`define DSD_I_DWD_LO   15

// Masks and reset values
`define DSD_M_INT      30'h000FFFFF
`define DSD_M_FRAC     30'h00FFFFFF
`define DSD_M_HI       30'h3FFFFFFF
`define DSD_M_LO       30'h0003FFFF
`define DSD_M_MOD      30'h2FFFFFFF
`define DSD_M_DIV      30'h00007FFF
`define DSD_R_MOD      30'h04478173
`define DSD_R_DIV      30'h000032CE
`define DSD_R_ZERO     30'h00000000

// Modulator configuration fields
`define DSD_MOD_REP_A      2
`define DSD_MOD_REP_B      3
`define DSD_MOD_RAMP_EN    11
`define DSD_MOD_SPI_START  12
`define DSD_MOD_TRIG_EN    13
`define DSD_MOD_BYPASS     14
`define DSD_MOD_CSP_LSB    15
`define DSD_MOD_CSP_MSB    18
`define DSD_MOD_EXT_SEQ    19
`define DSD_MOD_FALL_EDGE  20
`define DSD_MOD_LOCK_TRIG  21
`define DSD_MOD_SYM        22
`define DSD_MOD_INT_STROBE 23
`define DSD_MOD_SSTEP      24
`define DSD_MOD_SDIR       25
`define DSD_MOD_START_DIR  26
`define DSD_MOD_EXT_CLK    27
`define DSD_MOD_CSP_X16    29

// Divider configuration fields
`define DSD_DIV_DSM_WIDE   0
`define DSD_DIV_PFD_WIDE   1
`define DSD_DIV_RESET      5
`define DSD_DIV_PW_LSB     12
`define DSD_DIV_PW_MSB     14

// Divider pulse width base in oscillator cycles, and ratio that widening must exceed
`define DSD_PW_BASE        6'h05
`define DSD_WIDE_MIN_RATIO 64

`endif

/* File: rtl/dsd_pkg.sv */
package dsd_pkg;

  typedef logic [29:0] dsd_word_t;
  typedef logic [47:0] dsd_wide_t;

  typedef enum logic [0:0] {
    DSD_SW_IDLE = 1'b0,
    DSD_SW_RUN  = 1'b1
  } dsd_sweep_t;

endpackage : dsd_pkg

/* File: rtl/dsd_regfile.sv */
`timescale 1ns/1ns
`include "dsd_consts.svh"
module dsd_regfile import dsd_pkg::*; (
  input  wire logic                         i_clk,     // System clock
  input  wire logic                         i_reset_n, // Async reset, active low
  input  wire logic                         i_wr,      // Register write strobe
  input  wire logic                         i_rd,      // Register read strobe
  input  wire logic [4:0]                   i_addr,    // Register address
  input  wire dsd_word_t                    i_wdata,   // Write data
  input  wire dsd_word_t                    i_status,  // Live status word
  output logic      [`DSD_NREG-1:0][29:0]   o_regs,    // All stored registers
  output dsd_word_t                         o_rdata,   // Read data
  output logic                              o_int_wr,  // Accepted integer write
  output logic                              o_mod_wr   // Modulator config write
);

  localparam logic [4:0] ADDR_TBL [`DSD_NREG] = '{
    `DSD_A_INT, `DSD_A_FRAC, `DSD_A_NDN_HI, `DSD_A_NDN_LO, `DSD_A_MOD, `DSD_A_DIV,
    `DSD_A_DWU_HI, `DSD_A_DWU_LO, `DSD_A_STU_HI, `DSD_A_STU_LO, `DSD_A_NU_HI,
    `DSD_A_NU_LO, `DSD_A_STD_HI, `DSD_A_STD_LO, `DSD_A_DWD_HI, `DSD_A_DWD_LO};
  localparam dsd_word_t MASK_TBL [`DSD_NREG] = '{
    `DSD_M_INT, `DSD_M_FRAC, `DSD_M_HI, `DSD_M_LO, `DSD_M_MOD, `DSD_M_DIV,
    `DSD_M_HI, `DSD_M_LO, `DSD_M_HI, `DSD_M_LO, `DSD_M_HI,
    `DSD_M_LO, `DSD_M_HI, `DSD_M_LO, `DSD_M_HI, `DSD_M_LO};

  logic lock_block;

  // While trigger lock is armed the ratio registers refuse writes
  assign lock_block = o_regs[`DSD_I_MOD][`DSD_MOD_LOCK_TRIG];
  assign o_int_wr   = i_wr && (i_addr == `DSD_A_INT) && !lock_block;
  assign o_mod_wr   = i_wr && (i_addr == `DSD_A_MOD);

  // One storage word per mapped register
  for (genvar g = 0; g < `DSD_NREG; g++) begin : g_reg
    logic      hit;
    dsd_word_t store_q;
    assign hit = i_wr && (i_addr == ADDR_TBL[g]) &&
                 !(lock_block && (g == `DSD_I_INT || g == `DSD_I_FRAC));
    // Each word has its own flop so no process shares the packed output
    assign o_regs[g] = store_q;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        if (g == `DSD_I_MOD) begin
          store_q <= `DSD_R_MOD;
        end else if (g == `DSD_I_DIV) begin
          store_q <= `DSD_R_DIV;
        end else begin
          store_q <= `DSD_R_ZERO;
        end
      end else if (hit) begin
        store_q <= i_wdata & MASK_TBL[g];
      end
    end
  end

  // Read mux; unmapped addresses answer zero
  function automatic dsd_word_t rd_mux(input logic [4:0] a,
                                       input logic [`DSD_NREG-1:0][29:0] r,
                                       input dsd_word_t st);
    dsd_word_t v;
    v = '0;
    for (int k = 0; k < `DSD_NREG; k++) begin
      if (a == ADDR_TBL[k]) begin
        v = r[k];
      end
    end
    if (a == `DSD_A_STAT) begin
      v = st;
    end
    return v;
  endfunction : rd_mux

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      o_rdata <= rd_mux(i_addr, o_regs, i_status);
    end
  end

endmodule : dsd_regfile

/* File: rtl/dsd_modulator.sv */
`timescale 1ns/1ns
module dsd_modulator import dsd_pkg::*; #(
  parameter int INT_W = 20  // Integer ratio width
) (
  input  wire logic             i_clk,      // System clock
  input  wire logic             i_reset_n,  // Async reset, active low
  input  wire logic             i_tick,     // Modulator clock rising edge
  input  wire logic             i_seq_tick, // External sequence sample edge
  input  wire logic             i_bypass,   // Integer only output
  input  wire logic             i_ext_seq,  // Use imported sequence
  input  wire logic [INT_W-1:0] i_int,      // Integer setpoint
  input  wire dsd_wide_t        i_frac,     // Fraction word
  input  wire logic [4:0]       i_seq,      // Imported sequence (signed)
  output logic      [INT_W-1:0] o_ratio     // Instantaneous division ratio
);

  if (INT_W < 8 || INT_W > 30) begin : g_bad_width
    $error("dsd_modulator: INT_W must lie in 8..30");
  end

  dsd_wide_t        acc_q;
  logic [4:0]       seq_q;
  logic [48:0]      sum;
  logic [INT_W-1:0] seq_ext;

  assign sum     = {1'b0, acc_q} + {1'b0, i_frac};
  assign seq_ext = {{(INT_W-5){seq_q[4]}}, seq_q};

  // Accumulator keeps running even in bypass so re-entry is seamless
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      acc_q <= '0;
    end else if (i_tick) begin
      acc_q <= sum[47:0];
    end
  end

  // Imported sequence capture on the chosen edge
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seq_q <= '0;
    end else if (i_seq_tick) begin
      seq_q <= i_seq;
    end
  end

  // Ratio selection: bypass first, then imported, then internal carry
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ratio <= '0;
    end else if (i_tick) begin
      if (i_bypass) begin
        o_ratio <= i_int;
      end else if (i_ext_seq) begin
        o_ratio <= i_int + seq_ext;
      end else begin
        o_ratio <= i_int + INT_W'(sum[48]);
      end
    end
  end

endmodule : dsd_modulator

/* File: rtl/dsd_top.sv */
`timescale 1ns/1ns
`include "dsd_consts.svh"
module dsd_top import dsd_pkg::*; #(
  parameter int INT_W = 20  // Integer ratio width
) (
  input  wire logic             i_clk,              // 10 MHz system clock
  input  wire logic             i_reset_n,          // Async reset, active low
  input  wire logic             i_reg_wr,           // Register write strobe
  input  wire logic             i_reg_rd,           // Register read strobe
  input  wire logic [4:0]       i_reg_addr,         // Register address
  input  wire dsd_word_t        i_reg_wdata,        // Register write data
  output dsd_word_t             o_reg_rdata,        // Register read data
  input  wire logic             i_div_clk,          // Internal divided clock level
  input  wire logic             i_gpio_clk,         // GPIO clock level
  input  wire logic [4:0]       i_gpio_seq,         // GPIO imported sequence
  input  wire logic             i_ext_trig,         // External trigger pin
  output logic      [INT_W-1:0] o_div_ratio,        // Ratio to RF divider
  output logic                  o_div_reset,        // Holds RF divider in reset
  output logic      [5:0]       o_div_pulse_cycles, // Output pulse width, osc cycles
  output logic                  o_dsm_clk_widen,    // Widen modulator clock pulse
  output logic                  o_pfd_low_stretch,  // Stretch low phase to detector
  output logic      [7:0]       o_csp_step,         // Cycle slip guard step
  output logic                  o_lock_start,       // One-cycle lock start pulse
  output logic                  o_ramp_busy,        // Sweep in progress
  output logic                  o_ramp_dir          // Current sweep direction
);

  if (INT_W < 8 || INT_W > 30) begin : g_bad_width
    $error("dsd_top: INT_W must lie in 8..30");
  end

  logic [`DSD_NREG-1:0][29:0] regs;
  dsd_word_t  mod_cfg;
  dsd_word_t  div_cfg;
  logic       int_wr;
  logic       mod_wr;
  dsd_word_t  status;

  dsd_regfile u_regs (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_wr      (i_reg_wr),
    .i_rd      (i_reg_rd),
    .i_addr    (i_reg_addr),
    .i_wdata   (i_reg_wdata),
    .i_status  (status),
    .o_regs    (regs),
    .o_rdata   (o_reg_rdata),
    .o_int_wr  (int_wr),
    .o_mod_wr  (mod_wr)
  );

  assign mod_cfg = regs[`DSD_I_MOD];
  assign div_cfg = regs[`DSD_I_DIV];

  // Configuration bits by name
  logic ramp_en;
  logic trig_en;
  logic sym;
  logic sstep;
  logic sdir;
  logic auto_rep;
  assign ramp_en  = mod_cfg[`DSD_MOD_RAMP_EN];
  assign trig_en  = mod_cfg[`DSD_MOD_TRIG_EN];
  assign sym      = mod_cfg[`DSD_MOD_SYM];
  assign sstep    = mod_cfg[`DSD_MOD_SSTEP];
  assign sdir     = mod_cfg[`DSD_MOD_SDIR];
  assign auto_rep = mod_cfg[`DSD_MOD_REP_A] & mod_cfg[`DSD_MOD_REP_B];

  // ------------------------------------------------------------------
  // Modulator clock source and its edges; inputs are already synchronous
  // ------------------------------------------------------------------
  logic mclk;
  logic mclk_q;
  logic mclk_rise;
  logic mclk_fall;
  logic seq_tick;
  assign mclk      = mod_cfg[`DSD_MOD_EXT_CLK] ? i_gpio_clk : i_div_clk;
  assign mclk_rise = mclk & ~mclk_q;
  assign mclk_fall = ~mclk & mclk_q;
  assign seq_tick  = mod_cfg[`DSD_MOD_FALL_EDGE] ? mclk_fall : mclk_rise;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mclk_q <= 1'b0;
    end else begin
      mclk_q <= mclk;
    end
  end

  // ------------------------------------------------------------------
  // Trigger edge, start and strobe sources
  // ------------------------------------------------------------------
  logic trig_q;
  logic trig_rise;
  logic spi_start;
  logic go_pulse;
  assign trig_rise = i_ext_trig & ~trig_q;
  // A write with the start bit set acts as the software start or step strobe
  assign spi_start = mod_wr && i_reg_wdata[`DSD_MOD_SPI_START];
  assign go_pulse  = spi_start || (trig_en && trig_rise);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= i_ext_trig;
    end
  end

  // ------------------------------------------------------------------
  // Sweep parameter selection by direction and symmetry
  // ------------------------------------------------------------------
  logic      dir_q;
  logic      use_down;
  dsd_wide_t step_sel;
  dsd_wide_t nstep_sel;
  dsd_wide_t dwell_sel;
  assign use_down  = !dir_q && !sym;
  assign step_sel  = use_down ? {regs[`DSD_I_STD_HI], regs[`DSD_I_STD_LO][17:0]}
                              : {regs[`DSD_I_STU_HI], regs[`DSD_I_STU_LO][17:0]};
  assign nstep_sel = use_down ? {regs[`DSD_I_NDN_HI], regs[`DSD_I_NDN_LO][17:0]}
                              : {regs[`DSD_I_NU_HI], regs[`DSD_I_NU_LO][17:0]};
  assign dwell_sel = use_down ? {regs[`DSD_I_DWD_HI], regs[`DSD_I_DWD_LO][17:0]}
                              : {regs[`DSD_I_DWU_HI], regs[`DSD_I_DWU_LO][17:0]};

  // ------------------------------------------------------------------
  // Sweep engine, advanced on modulator clock rising edges
  // ------------------------------------------------------------------
  dsd_sweep_t state_q;
  logic       start_dir_q;
  logic       leg_q;
  logic       start_pend_q;
  logic       strobe_pend_q;
  dsd_wide_t  offset_q;
  dsd_wide_t  dwell_cnt_q;
  dsd_wide_t  step_cnt_q;
  logic       dwell_done;
  logic       advance;
  logic       leg_end;
  logic       run_tick;
  logic       start_tick;

  // Zero dwell behaves as one modulator cycle
  assign dwell_done = (dwell_cnt_q + 48'h1) >= dwell_sel;
  assign run_tick   = (state_q == DSD_SW_RUN) && mclk_rise && ramp_en;
  assign advance    = run_tick && (sstep ? strobe_pend_q : dwell_done);
  assign leg_end    = (step_cnt_q + 48'h1) >= nstep_sel;
  assign start_tick = (state_q == DSD_SW_IDLE) && mclk_rise && ramp_en && start_pend_q;

  // Start direction follows the register only while ramping is off
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      start_dir_q <= 1'b1;
    end else if (!ramp_en) begin
      start_dir_q <= mod_cfg[`DSD_MOD_START_DIR];
    end
  end

  // Pending requests bridge clock cycles to the slower modulator edge;
  // a new request in the consuming cycle wins over the clear
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      start_pend_q <= 1'b0;
    end else if (go_pulse && ramp_en) begin
      start_pend_q <= 1'b1;
    end else if (start_tick || !ramp_en) begin
      start_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      strobe_pend_q <= 1'b0;
    end else if (go_pulse && ramp_en && state_q == DSD_SW_RUN) begin
      strobe_pend_q <= 1'b1;
    end else if (advance || state_q == DSD_SW_IDLE) begin
      strobe_pend_q <= 1'b0;
    end
  end

  // State, direction, leg and counters
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q     <= DSD_SW_IDLE;
      dir_q       <= 1'b1;
      leg_q       <= 1'b0;
      dwell_cnt_q <= '0;
      step_cnt_q  <= '0;
    end else if (!ramp_en) begin
      state_q     <= DSD_SW_IDLE;
      dir_q       <= start_dir_q;
      leg_q       <= 1'b0;
      dwell_cnt_q <= '0;
      step_cnt_q  <= '0;
    end else if (start_tick) begin
      state_q     <= DSD_SW_RUN;
      dir_q       <= start_dir_q;
      leg_q       <= 1'b0;
      dwell_cnt_q <= '0;
      step_cnt_q  <= '0;
    end else if (advance) begin
      dwell_cnt_q <= '0;
      if (!leg_end) begin
        step_cnt_q <= step_cnt_q + 48'h1;
      end else if (!sdir && !leg_q) begin
        leg_q      <= 1'b1;  // Turn round for the return leg
        dir_q      <= ~dir_q;
        step_cnt_q <= '0;
      end else begin
        step_cnt_q <= '0;
        leg_q      <= 1'b0;
        dir_q      <= start_dir_q;
        if (!auto_rep) begin
          state_q <= DSD_SW_IDLE;
        end
      end
    end else if (run_tick && !sstep) begin
      dwell_cnt_q <= dwell_cnt_q + 48'h1;
    end
  end

  // Frequency offset from base; wraps modulo the fraction width
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      offset_q <= '0;
    end else if (!ramp_en || start_tick) begin
      offset_q <= '0;
    end else if (advance) begin
      if (leg_end && (sdir || leg_q) && (sdir || auto_rep || !leg_q)) begin
        offset_q <= sdir ? '0 : offset_q + (dir_q ? step_sel : -step_sel);
      end else begin
        offset_q <= dir_q ? offset_q + step_sel : offset_q - step_sel;
      end
    end
  end

  assign status = 30'({leg_q, dir_q, state_q == DSD_SW_RUN});

  // ------------------------------------------------------------------
  // Modulator: static setpoint, or base plus sweep offset
  // ------------------------------------------------------------------
  dsd_wide_t frac_word;
  assign frac_word = ramp_en ? {regs[`DSD_I_FRAC][23:0], 24'h0} + offset_q
                             : {regs[`DSD_I_FRAC][23:0], 24'h0};

  dsd_modulator #(
    .INT_W (INT_W)
  ) u_mod (
    .i_clk      (i_clk),
    .i_reset_n  (i_reset_n),
    .i_tick     (mclk_rise),
    .i_seq_tick (seq_tick),
    .i_bypass   (mod_cfg[`DSD_MOD_BYPASS]),
    .i_ext_seq  (mod_cfg[`DSD_MOD_EXT_SEQ]),
    .i_int      (regs[`DSD_I_INT][INT_W-1:0]),
    .i_frac     (frac_word),
    .i_seq      (i_gpio_seq),
    .o_ratio    (o_div_ratio)
  );

  // ------------------------------------------------------------------
  // Lock start: trigger gated, or integer write strobe
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_lock_start <= 1'b0;
    end else begin
      o_lock_start <= (mod_cfg[`DSD_MOD_LOCK_TRIG] && trig_rise) ||
                      (mod_cfg[`DSD_MOD_INT_STROBE] && int_wr);
    end
  end

  // ------------------------------------------------------------------
  // Divider side controls, registered for clean outputs
  // ------------------------------------------------------------------
  logic [3:0] csp_raw;
  assign csp_raw = mod_cfg[`DSD_MOD_CSP_MSB:`DSD_MOD_CSP_LSB];

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_div_reset        <= 1'b0;
      o_div_pulse_cycles <= `DSD_PW_BASE;
      o_dsm_clk_widen    <= 1'b0;
      o_pfd_low_stretch  <= 1'b0;
      o_csp_step         <= '0;
    end else begin
      o_div_reset        <= div_cfg[`DSD_DIV_RESET];
      o_div_pulse_cycles <= `DSD_PW_BASE +
                            {div_cfg[`DSD_DIV_PW_MSB:`DSD_DIV_PW_LSB], 3'b000};
      // Widening is only meaningful for long divided periods
      o_dsm_clk_widen    <= div_cfg[`DSD_DIV_DSM_WIDE] &&
                            (o_div_ratio > INT_W'(`DSD_WIDE_MIN_RATIO));
      o_pfd_low_stretch  <= div_cfg[`DSD_DIV_PFD_WIDE];
      o_csp_step         <= mod_cfg[`DSD_MOD_CSP_X16] ? {csp_raw, 4'h0}
                                                       : {4'h0, csp_raw};
    end
  end

  assign o_ramp_busy = (state_q == DSD_SW_RUN);
  assign o_ramp_dir  = dir_q;

endmodule : dsd_top

/* File: testbench/dsd_checker.sv */
`timescale 1ns/1ns
module dsd_checker import dsd_pkg::*; #(
  parameter int INT_W = 20  // Integer ratio width
) (
  input wire logic             i_clk,              // Clock
  input wire logic             i_reset_n,          // Reset, active low
  input wire logic             i_reg_wr,           // Write strobe
  input wire logic [4:0]       i_reg_addr,         // Address
  input wire dsd_word_t        i_reg_wdata,        // Write data
  input wire logic             i_ext_trig,         // Trigger pin
  input wire logic [INT_W-1:0] o_div_ratio,        // Ratio
  input wire logic             o_div_reset,        // Divider reset
  input wire logic [5:0]       o_div_pulse_cycles, // Pulse width
  input wire logic             o_dsm_clk_widen,    // Widen
  input wire logic             o_pfd_low_stretch,  // Low stretch
  input wire logic [7:0]       o_csp_step,         // Guard step
  input wire logic             o_lock_start,       // Lock pulse
  input wire logic             o_ramp_busy         // Sweep busy
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Register write decodes, two edges from write to output
  wire div_wr = i_reg_wr && i_reg_addr == 5'h0F;
  wire int_wr = i_reg_wr && i_reg_addr == 5'h06;
  a_pw_code: assert property (o_div_pulse_cycles[2:0] == 3'h5 && o_div_pulse_cycles <= 6'h3D)
    else $error("pulse width off grid");
  a_pw_follow: assert property (div_wr |=> ##1 o_div_pulse_cycles == 6'h05 + {$past(i_reg_wdata[14:12], 2), 3'h0})
    else $error("pulse width not from code");
  a_rst_follow: assert property (div_wr |=> ##1 o_div_reset == $past(i_reg_wdata[5], 2))
    else $error("divider reset not from bit");
  a_pfd_follow: assert property (div_wr |=> ##1 o_pfd_low_stretch == $past(i_reg_wdata[1], 2))
    else $error("low stretch not from bit");
  a_csp_form: assert property (o_csp_step <= 8'h0F || o_csp_step[3:0] == 4'h0)
    else $error("guard step not plain or times sixteen");
  a_widen_ratio: assert property (o_dsm_clk_widen |-> o_div_ratio > 64 || $past(o_div_ratio) > 64)
    else $error("widen at small ratio");
  a_lock_cause: assert property (o_lock_start |-> $past(i_ext_trig) || $past(i_ext_trig, 2) || $past(int_wr) || $past(int_wr, 2))
    else $error("lock start without cause");
  a_reset_vals: assert property ($rose(i_reset_n) |-> ##1 o_csp_step == 8'h0F && o_div_pulse_cycles == 6'h1D)
    else $error("reset values wrong");
  c_busy: cover property ($rose(o_ramp_busy));
  c_lock: cover property (o_lock_start);
  c_divrst: cover property (o_div_reset);
endmodule : dsd_checker
bind dsd_top dsd_checker #(.INT_W(INT_W)) u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_ext_trig(i_ext_trig), .o_div_ratio(o_div_ratio), .o_div_reset(o_div_reset),
  .o_div_pulse_cycles(o_div_pulse_cycles), .o_dsm_clk_widen(o_dsm_clk_widen),
  .o_pfd_low_stretch(o_pfd_low_stretch), .o_csp_step(o_csp_step),
  .o_lock_start(o_lock_start), .o_ramp_busy(o_ramp_busy));

/* File: testbench/dsd_far_model.sv */
`timescale 1ns/1ns
module dsd_far_model (
  input  wire logic i_clk,     // System clock
  input  wire logic i_fire,    // Bench asks for a trigger
  output logic      o_div_clk, // Divided clock level
  output logic      o_trig     // External trigger pin
);
  logic [1:0] cnt_q;
  initial begin
    cnt_q = 2'h0;
    o_div_clk = 1'b0;
    o_trig = 1'b0;
  end
  // Divided clock at an eighth of the system rate, so ticks are rare
  always @(posedge i_clk) begin
    cnt_q <= cnt_q + 2'h1;
    if (cnt_q == 2'h3) o_div_clk <= ~o_div_clk;
    o_trig <= i_fire;
  end
endmodule : dsd_far_model

/* File: testbench/test_dsm_sweep_divider_control.sv */
`timescale 1ns/1ns
module test_dsm_sweep_divider_control import dsd_pkg::*;;
  logic clk, rst_n, wr, rd, dclk, trig, fire, dres, wid, pfd, lock, busy, dir, seen;
  logic [4:0] addr, seq;
  dsd_word_t wdata, rdata;
  logic [19:0] ratio;
  logic [5:0] pw;
  logic [7:0] cycle_slip_guard;
  int bad_count, num_checks;
  dsd_top uut (.i_clk(clk), .i_reset_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_div_clk(dclk),
    .i_gpio_clk(dclk), .i_gpio_seq(seq), .i_ext_trig(trig), .o_div_ratio(ratio),
    .o_div_reset(dres), .o_div_pulse_cycles(pw), .o_dsm_clk_widen(wid),
    .o_pfd_low_stretch(pfd), .o_csp_step(cycle_slip_guard), .o_lock_start(lock),
    .o_ramp_busy(busy), .o_ramp_dir(dir));
  dsd_far_model far (.i_clk(clk), .i_fire(fire), .o_div_clk(dclk), .o_trig(trig));
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [29:0] got, input logic [29:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [4:0] a, input dsd_word_t d);
    cyc(1); wr = 1'b1; addr = a; wdata = d;
    cyc(1); wr = 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [4:0] a, input dsd_word_t e);
    cyc(1); rd = 1'b1; addr = a;
    cyc(1); rd = 1'b0; chk("rdata", rdata, e);
  endtask : rd_chk
  // Bounded wait for lock pulse (w=0) or busy (w=1)
  task automatic wait_hi(input string nm, input int w, input int n);
    seen = 1'b0;
    // Look before each edge so a pulse launched by the last write is not missed
    for (int i = 0; i < n && seen !== 1'b1; i++) begin
      if ((w == 0 ? lock : busy) === 1'b1) seen = 1'b1;
      else cyc(1);
    end
    chk(nm, seen, 30'h1);
  endtask : wait_hi
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #300000; bad_count++; end_sim;
  end
  initial begin
    {rst_n, wr, rd, fire} = 4'h0; addr = 5'h00; wdata = '0; seq = 5'h00;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    rd_chk(5'h0E, 30'h04478173);
    rd_chk(5'h0F, 30'h000032CE);
    chk("pw", pw, 30'h1D); chk("csp", cycle_slip_guard, 30'h0F);
    wr_reg(5'h10, 30'h3FFFFFFF); rd_chk(5'h10, 30'h3FFFFFFF);
    wr_reg(5'h11, 30'h3FFFFFFF); rd_chk(5'h11, 30'h0003FFFF);
    for (int c = 0; c < 8; c++) begin
      wr_reg(5'h0F, {15'h0, c[2:0], 12'h023}); cyc(1);
      chk("pw", pw, 30'h5 + 30'(8 * c)); chk("dres", dres, 30'h1);
    end
    wr_reg(5'h0F, 30'h0); cyc(1);
    chk("dres", dres, 30'h0); chk("pfd", pfd, 30'h0);
    wr_reg(5'h0E, 30'h00050000); cyc(1); chk("csp", cycle_slip_guard, 30'h0A);
    wr_reg(5'h0E, 30'h20050000); cyc(1); chk("csp", cycle_slip_guard, 30'hA0);
    // Half fraction would dither the ratio unless bypassed
    wr_reg(5'h06, 30'h64); wr_reg(5'h07, 30'h800000); wr_reg(5'h0E, 30'h00004000);
    repeat (4) begin
      cyc(8); chk("ratio", ratio, 30'h64);
    end
    wr_reg(5'h0F, 30'h1); cyc(2); chk("wid", wid, 30'h1);
    for (int e = 0; e < 2; e++) begin
      wr_reg(5'h0E, 30'h00080000 | 30'(e << 20));
      seq = 5'h03; cyc(24); chk("ratio", ratio, 30'h67);
      seq = 5'h1F; cyc(24); chk("ratio", ratio, 30'h63);
    end
    wr_reg(5'h0E, 30'h00200000); wr_reg(5'h06, 30'hC8); rd_chk(5'h06, 30'h64);
    fire = 1'b1; wait_hi("lock", 0, 6); fire = 1'b0;
    wr_reg(5'h0E, 30'h00800000); wr_reg(5'h06, 30'hC8); wait_hi("lock", 0, 4);
    wr_reg(5'h10, 30'h0); wr_reg(5'h11, 30'h1); wr_reg(5'h15, 30'h2);
    // Direction loads only while ramping is off, so set it before enabling
    wr_reg(5'h0E, 30'h04400000); wr_reg(5'h0E, 30'h04400800); wr_reg(5'h0E, 30'h04401800);
    wait_hi("busy", 1, 30); chk("dir", dir, 30'h1);
    cyc(40); chk("busy", busy, 30'h0); chk("dir", dir, 30'h1);
    // Trigger start with auto repeat keeps the sweep running
    wr_reg(5'h0E, 30'h0440280C); cyc(16); chk("busy", busy, 30'h0);
    fire = 1'b1; wait_hi("busy", 1, 30); fire = 1'b0;
    cyc(80); chk("busy", busy, 30'h1);
    wr_reg(5'h0E, 30'h0); cyc(30); chk("busy", busy, 30'h0);
    end_sim;
  end
endmodule : test_dsm_sweep_divider_control
